// ---- bench/hpm_host_model.sv ----
`timescale 1ns/1ns
module hpm_host_model
	import hpm_pkg::*;
(
	// clock
	input  wire logic      clk,
	// host strobes toward the channels
	output logic [1:0]     hostWr,
	output logic [1:0]     hostCmd,
	output hpm_byte_t      hostWdata,
	output logic [1:0]     hostRd,
	// outbound latch copies
	input  wire hpm_byte_t hostRdata1,
	input  wire hpm_byte_t hostRdata2
);
	initial
	begin
		hostWr = 2'h0;
		hostCmd = 2'h0;
		hostWdata = 8'h00;
		hostRd = 2'h0;
	end

	// data and command lines flip once released so a stale byte never looks valid
	task automatic put(input int ch, input hpm_byte_t d, input logic c);
		@(posedge clk);
		hostWdata <= d;
		hostCmd[ch] <= c;
		hostWr[ch] <= 1'b1;
		@(posedge clk);
		hostWr <= 2'h0;
		hostWdata <= ~d;
		hostCmd <= ~hostCmd;
	endtask

	task automatic take(input int ch, output hpm_byte_t d);
		@(posedge clk);
		#1 d = (ch == 1) ? hostRdata2 : hostRdata1;
		@(posedge clk);
		hostRd[ch] <= 1'b1;
		@(posedge clk);
		hostRd <= 2'h0;
	endtask
endmodule // hpm_host_model

// ---- bench/tb_host_pm_channel_data_port.sv ----
`timescale 1ns/1ns
`include "hpm_consts.svh"
module tb_host_pm_channel_data_port
	import hpm_pkg::*;
;
	localparam logic [23:0] ST[2]  = '{`HPM1_ST_ADDR, `HPM2_ST_ADDR};
	localparam logic [23:0] DO[2]  = '{`HPM1_DO_ADDR, `HPM2_DO_ADDR};
	localparam logic [23:0] DI[2]  = '{`HPM1_DI_ADDR, `HPM2_DI_ADDR};
	localparam logic [23:0] DOC[2] = '{`HPM1_DOC_ADDR, `HPM2_DOC_ADDR};
	localparam logic [23:0] DOM[2] = '{`HPM1_DOM_ADDR, `HPM2_DOM_ADDR};
	localparam logic [23:0] DIC[2] = '{`HPM1_DIC_ADDR, `HPM2_DIC_ADDR};
	localparam logic [23:0] CTL[2] = '{`HPM1_CTL_ADDR, `HPM2_CTL_ADDR};

	logic                   clk = 1'b0;
	logic                   srst = 1'b1;
	logic [`HPM_ADDR_W-1:0] addr = '0;
	hpm_byte_t              wdata = 8'h00;
	logic                   wrStb = 1'b0;
	logic                   rdStb = 1'b0;
	logic                   sharedIbfIe = 1'b0;
	logic                   sharedObeIe = 1'b0;
	hpm_byte_t              rdata, hostWdata, hostRdata1, hostRdata2;
	logic [1:0]             hostWr, hostCmd, hostRd, hostSmi, hostSci;
	logic                   coreIrq;
	int                     bad_count = 0;
	int                     comparisons = 0;
	int                     cycles = 0;
	int                     seed = 8957;
	int                     smiN[2] = '{0, 0};
	int                     sciN[2] = '{0, 0};
	bit                     enhanced_mode_enable[2] = '{1'b0, 1'b1};
	hpm_byte_t              sentQ[$];

	hpm_top DUT (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wrStb(wrStb),
		.rdStb(rdStb), .rdata(rdata), .hostWr(hostWr), .hostCmd(hostCmd),
		.hostWdata(hostWdata), .hostRd(hostRd), .hostRdata1(hostRdata1),
		.hostRdata2(hostRdata2), .sharedIbfIe(sharedIbfIe), .sharedObeIe(sharedObeIe),
		.hostSmi(hostSmi), .hostSci(hostSci), .coreIrq(coreIrq));
	hpm_host_model HOST (.clk(clk), .hostWr(hostWr), .hostCmd(hostCmd),
		.hostWdata(hostWdata), .hostRd(hostRd), .hostRdata1(hostRdata1),
		.hostRdata2(hostRdata2));

	always #25 clk = ~clk;

	// pulses are counted rather than timed, so a late but single pulse still shows
	always @(posedge clk)
	begin
		cycles++;
		smiN[0] += hostSmi[0];
		smiN[1] += hostSmi[1];
		sciN[0] += hostSci[0];
		sciN[1] += hostSci[1];
		if (cycles == 5000)
		begin
			bad_count++;
			stop_test();
		end
	end

	task automatic chk(input hpm_byte_t seen, input hpm_byte_t exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [23:0] a, input hpm_byte_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
		wdata <= ~d;
	endtask

	task automatic rd(input logic [23:0] a, output hpm_byte_t d);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic rdchk(input logic [23:0] a, input hpm_byte_t exp);
		hpm_byte_t v;
		rd(a, v);
		chk(v, exp);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic out_test(input int ch, input int kind);
		hpm_byte_t d, v;
		int s0, c0;
		d = hpm_byte_t'($random(seed));
		s0 = smiN[ch];
		c0 = sciN[ch];
		wr(kind == 0 ? DO[ch] : (kind == 1 ? DOC[ch] : DOM[ch]), d);
		sentQ.push_back(d);
		idle(4);
		rd(ST[ch], v);
		chk(v & 8'h01, 8'h01);
		chk(hpm_byte_t'(smiN[ch] - s0), hpm_byte_t'(kind == 2 && enhanced_mode_enable[ch]));
		chk(hpm_byte_t'(sciN[ch] - c0), hpm_byte_t'(kind == 1 && enhanced_mode_enable[ch]));
		HOST.take(ch, v);
		chk(v, sentQ.pop_front());
		idle(2);
		rd(ST[ch], v);
		chk(v & 8'h01, 8'h00);
	endtask

	task automatic in_test(input int ch, input bit sci);
		hpm_byte_t d, v;
		int c0;
		d = hpm_byte_t'($random(seed));
		c0 = sciN[ch];
		HOST.put(ch, d, sci);
		idle(3);
		rd(ST[ch], v);
		chk(v & 8'h0a, sci ? 8'h0a : 8'h02);
		rd(sci ? DIC[ch] : DI[ch], v);
		chk(v, d);
		idle(3);
		chk(hpm_byte_t'(sciN[ch] - c0), hpm_byte_t'(sci && enhanced_mode_enable[ch]));
		rd(ST[ch], v);
		chk(v & 8'h02, 8'h00);
	endtask

	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		hpm_byte_t v;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		rdchk(CTL[0], 8'h40);
		rdchk(CTL[1], 8'hc0);
		rdchk(ST[0], 8'h00);
		rdchk(DO[0], 8'h00);
		rdchk(24'hfff700, 8'h00);
		rdchk(`HPM_EVMASK_ADDR, 8'h00);
		wr(CTL[1], 8'h00);
		rdchk(CTL[1], 8'h80);
		wr(CTL[1], 8'h01);
		for (int p = 0; p < 2; p++)
		begin
			if (p == 1)
			begin
				wr(CTL[0], 8'h80);
				enhanced_mode_enable[0] = 1'b1;
			end
			for (int ch = 0; ch < 2; ch++)
				for (int k = 0; k < 3; k++)
					out_test(ch, k);
		end
		rdchk(CTL[0], 8'h80);
		for (int ch = 0; ch < 2; ch++)
			for (int s = 0; s < 2; s++)
				in_test(ch, s[0]);
		// smi and sci pulses of both enhanced channels latch too, plus channel two input full
		rdchk(`HPM_EVST_ADDR, 8'hdc);
		rdchk(`HPM_EVST_ADDR, 8'h00);
		wr(`HPM_EVMASK_ADDR, 8'h13);
		HOST.put(1, 8'h5a, 1'b0);
		idle(4);
		chk({7'h00, coreIrq}, 8'h01);
		rdchk(`HPM_EVST_ADDR, 8'h10);
		idle(2);
		chk({7'h00, coreIrq}, 8'h00);
		rdchk(DI[1], 8'h5a);
		sharedIbfIe <= 1'b1;
		sharedObeIe <= 1'b1;
		HOST.put(0, 8'ha5, 1'b0);
		idle(4);
		rd(DI[0], v);
		rdchk(`HPM_EVST_ADDR, 8'h00);
		wr(CTL[0], 8'h00);
		enhanced_mode_enable[0] = 1'b0;
		HOST.put(0, 8'h3c, 1'b0);
		idle(4);
		rd(DI[0], v);
		out_test(0, 0);
		rdchk(`HPM_EVST_ADDR, 8'h03);
		wr(ST[0], 8'hff);
		rdchk(ST[0], 8'hf4);
		stop_test();
	end
endmodule // tb_host_pm_channel_data_port

// ---- src/hpm_channel.sv ----
`timescale 1ns/1ns
`include "hpm_consts.svh"
module hpm_channel
	import hpm_pkg::*;
#(
	parameter bit FIXED_EME = 1'b0
)
(
	// clock and reset
	input  wire logic      clk,
	input  wire logic      srst,
	// core-side strobes
	input  wire logic      wrData,
	input  wire logic      wrSci,
	input  wire logic      wrSmi,
	input  wire logic      rdData,
	input  wire logic      rdSci,
	input  wire logic      wrSt,
	input  wire logic      wrCtl,
	input  wire hpm_byte_t wdata,
	// host-side events, one cycle pulses
	input  wire logic      hostWrPulse,
	input  wire logic      hostCmd,
	input  wire hpm_byte_t hostWdata,
	input  wire logic      hostRdPulse,
	// state
	output hpm_byte_t      outLatch_r,
	output hpm_byte_t      inLatch_r,
	output hpm_byte_t      status_r,
	output hpm_byte_t      ctl_r,
	output logic           smiPending_r,
	output logic           sciPending_r,
	output logic           inSci_r,
	output logic           smiPulse_r,
	output logic           sciPulse_r
);
	logic enhanced_mode_enable;
	logic outWr;
	assign enhanced_mode_enable   = ctl_r[`HPM_CTL_EME_BIT];
	assign outWr = wrData | wrSci | wrSmi;

	always_ff @(posedge clk)
	begin
		if (srst)
			ctl_r <= FIXED_EME ? `HPM_CTL2_RST : `HPM_CTL1_RST;
		else if (wrCtl)
			// channel two pins enhanced mode on
			ctl_r <= (wdata & `HPM_CTL_RW_MASK)
				| {(FIXED_EME | wdata[`HPM_CTL_EME_BIT]), 7'h00};
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			outLatch_r <= 8'h00;
		else if (outWr)
			outLatch_r <= wdata;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			inLatch_r <= 8'h00;
		else if (hostWrPulse)
			inLatch_r <= hostWdata;
	end

	// flags: hardware set wins over any clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (srst)
			status_r <= `HPM_ST_RST;
		else
		begin
			if (wrSt)
				status_r[7:4] <= wdata[7:4];
			if (wrSt)
				status_r[`HPM_ST_F0_BIT] <= wdata[`HPM_ST_F0_BIT];
			if (hostWrPulse)
				status_r[`HPM_ST_CMD_BIT] <= hostCmd;
			if (outWr)
				status_r[`HPM_ST_OBF_BIT] <= 1'b1;
			else if (hostRdPulse)
				status_r[`HPM_ST_OBF_BIT] <= 1'b0;
			if (hostWrPulse)
				status_r[`HPM_ST_IBF_BIT] <= 1'b1;
			else if (rdData | rdSci)
				status_r[`HPM_ST_IBF_BIT] <= 1'b0;
		end
	end

	// pending flags follow the output-full flag down
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			smiPending_r <= 1'b0;
			sciPending_r <= 1'b0;
		end
		else
		begin
			if (wrSmi)
				smiPending_r <= 1'b1;
			else if (outWr | hostRdPulse)
				smiPending_r <= 1'b0;
			if (wrSci)
				sciPending_r <= 1'b1;
			else if (outWr | hostRdPulse)
				sciPending_r <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			inSci_r <= 1'b0;
		else if (rdSci)
			inSci_r <= 1'b1;
		else if (hostWrPulse)
			inSci_r <= 1'b0;
	end

	// automatic notifications only in enhanced mode
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			smiPulse_r <= 1'b0;
			sciPulse_r <= 1'b0;
		end
		else
		begin
			smiPulse_r <= enhanced_mode_enable & wrSmi;
			sciPulse_r <= enhanced_mode_enable & (wrSci | rdSci);
		end
	end

	ctl_eme_a: assert property (@(posedge clk) disable iff (srst)
		FIXED_EME |-> ctl_r[`HPM_CTL_EME_BIT])
		else $error("channel two left enhanced mode");
	plain_nosig_a: assert property (@(posedge clk) disable iff (srst)
		wrData && !wrSci && !wrSmi && !rdSci |=> !smiPulse_r && !sciPulse_r)
		else $error("plain write raised a notification");
	smi_pend_a: assert property (@(posedge clk) disable iff (srst)
		wrSmi |=> smiPending_r && status_r[`HPM_ST_OBF_BIT])
		else $error("smi write did not set flags");
	smi_clear_a: assert property (@(posedge clk) disable iff (srst)
		smiPending_r |-> status_r[`HPM_ST_OBF_BIT])
		else $error("smi pending outlived output full");
	sci_clear_a: assert property (@(posedge clk) disable iff (srst)
		sciPending_r |-> status_r[`HPM_ST_OBF_BIT])
		else $error("sci pending outlived output full");
	insci_set_a: assert property (@(posedge clk) disable iff (srst)
		rdSci && !hostWrPulse |=> inSci_r && !status_r[`HPM_ST_IBF_BIT])
		else $error("sci read did not clear input full");
	legacy_quiet_a: assert property (@(posedge clk) disable iff (srst)
		!enhanced_mode_enable && (wrSmi || wrSci || rdSci) |=> !smiPulse_r && !sciPulse_r)
		else $error("legacy mode raised a notification");
	outlatch_a: assert property (@(posedge clk) disable iff (srst)
		outWr |=> outLatch_r == $past(wdata))
		else $error("output latch not loaded");
	inlatch_a: assert property (@(posedge clk) disable iff (srst)
		hostWrPulse |=> inLatch_r == $past(hostWdata) && status_r[`HPM_ST_IBF_BIT])
		else $error("input latch not loaded");

	smi_path_c: cover property (@(posedge clk) wrSmi ##1 smiPulse_r);
	sci_read_c: cover property (@(posedge clk) rdSci ##1 sciPulse_r);
	host_rd_c: cover property (@(posedge clk) sciPending_r ##1 hostRdPulse ##1 !sciPending_r);
endmodule // hpm_channel

// ---- src/hpm_consts.svh ----
`ifndef HPM_CONSTS_SVH
`define HPM_CONSTS_SVH

`define HPM_ADDR_W        24
// per-channel register offsets (byte addresses, channel 1 then channel 2)
`define HPM1_ST_ADDR      24'hfff78c
`define HPM1_DO_ADDR      24'hfff78e
`define HPM1_DI_ADDR      24'hfff790
`define HPM1_DOC_ADDR     24'hfff792
`define HPM1_DOM_ADDR     24'hfff794
`define HPM1_DIC_ADDR     24'hfff796
`define HPM1_CTL_ADDR     24'hfff798
`define HPM2_ST_ADDR      24'hfff79e
`define HPM2_DO_ADDR      24'hfff7a0
`define HPM2_DI_ADDR      24'hfff7a2
`define HPM2_DOC_ADDR     24'hfff7a4
`define HPM2_DOM_ADDR     24'hfff7a6
`define HPM2_DIC_ADDR     24'hfff7a8
`define HPM2_CTL_ADDR     24'hfff7aa
// block-level event status and mask
`define HPM_EVST_ADDR     24'hfff7b0
`define HPM_EVMASK_ADDR   24'hfff7b2

// control register fields
`define HPM_CTL_EME_BIT   7
`define HPM_CTL_OBEIE_BIT 1
`define HPM_CTL_IBFIE_BIT 0
`define HPM_CTL_RW_MASK   8'h7b
`define HPM_CTL1_RST      8'h40
`define HPM_CTL2_RST      8'hc0

// status register fields
`define HPM_ST_OBF_BIT    0
`define HPM_ST_IBF_BIT    1
`define HPM_ST_F0_BIT     2
`define HPM_ST_CMD_BIT    3
`define HPM_ST_WR_MASK    8'hf4
`define HPM_ST_RST        8'h00

// event status bit layout, four per channel
`define HPM_EV_IBF        0
`define HPM_EV_OBE        1
`define HPM_EV_SMI        2
`define HPM_EV_SCI        3
`define HPM_EV_RST        8'h00

`endif

// ---- src/hpm_pkg.sv ----
package hpm_pkg;
	typedef logic [7:0] hpm_byte_t;
	typedef enum logic [2:0] {
		HPM_NONE, HPM_ST, HPM_DO, HPM_DI, HPM_DOC, HPM_DOM, HPM_DIC, HPM_CTL
	} hpm_reg_e;
endpackage

// ---- src/hpm_sync.sv ----
`timescale 1ns/1ns
module hpm_sync
(
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// async level in, synchronised level out
	input  wire logic din,
	output logic      dout
);
	logic meta_r;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			meta_r <= 1'b0;
			dout   <= 1'b0;
		end
		else
		begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule // hpm_sync

// ---- src/hpm_top.sv ----
`timescale 1ns/1ns
`include "hpm_consts.svh"
// Summary of operation
// - input data register returns the byte the host last wrote
// - control bit 7 enables enhanced mode; cleared means legacy mode
// - legacy mode: status flags still follow host and core accesses, no SMI or SCI pulses
// - legacy mode: core interrupt events follow shared enable inputs; channel one resets legacy
// - enhanced mode: shared bits ignored, per-channel controls govern interrupts
// - plain output write sets output-full, raises neither SMI nor SCI
// - SMI output write sets output-full and SMI pending, pulses SMI
// - SCI output write sets output-full and SCI pending, pulses SCI
// - SCI input read clears input-full, sets input-SCI, pulses SCI
module hpm_top
	import hpm_pkg::*;
(
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     srst,
	// core register port
	input  wire logic [`HPM_ADDR_W-1:0]   addr,
	input  wire hpm_byte_t                wdata,
	input  wire logic                     wrStb,
	input  wire logic                     rdStb,
	output hpm_byte_t                     rdata,
	// host side per channel, strobes already on clk
	input  wire logic [1:0]               hostWr,
	input  wire logic [1:0]               hostCmd,
	input  wire hpm_byte_t                hostWdata,
	input  wire logic [1:0]               hostRd,
	output hpm_byte_t                     hostRdata1,
	output hpm_byte_t                     hostRdata2,
	// shared legacy interrupt enables, from pins
	input  wire logic                     sharedIbfIe,
	input  wire logic                     sharedObeIe,
	// host notifications
	output logic [1:0]                    hostSmi,
	output logic [1:0]                    hostSci,
	// core interrupt
	output logic                          coreIrq
);
	hpm_byte_t     out1, out2, in1, in2, st1, st2, ctl1, ctl2;
	logic [1:0]    smiPend, sciPend, inSci, smiP, sciP;
	logic [1:0]    ibfIeSync;
	hpm_byte_t     evStatus_r, evMask_r;
	logic [1:0]    obfPrev_r, ibfPrev_r;
	logic [1:0]    chWrData, chWrSci, chWrSmi, chRdData, chRdSci, chWrSt, chWrCtl;
	hpm_reg_e      sel;
	logic          ch2;
	logic          evRead;

	// decode an address into register and channel
	function automatic hpm_reg_e dec_reg(input logic [`HPM_ADDR_W-1:0] a);
		unique case (a)
			`HPM1_ST_ADDR, `HPM2_ST_ADDR:   dec_reg = HPM_ST;
			`HPM1_DO_ADDR, `HPM2_DO_ADDR:   dec_reg = HPM_DO;
			`HPM1_DI_ADDR, `HPM2_DI_ADDR:   dec_reg = HPM_DI;
			`HPM1_DOC_ADDR, `HPM2_DOC_ADDR: dec_reg = HPM_DOC;
			`HPM1_DOM_ADDR, `HPM2_DOM_ADDR: dec_reg = HPM_DOM;
			`HPM1_DIC_ADDR, `HPM2_DIC_ADDR: dec_reg = HPM_DIC;
			`HPM1_CTL_ADDR, `HPM2_CTL_ADDR: dec_reg = HPM_CTL;
			default:                        dec_reg = HPM_NONE;
		endcase
	endfunction

	assign sel = dec_reg(addr);
	assign ch2 = addr >= `HPM2_ST_ADDR;
	assign evRead = rdStb && addr == `HPM_EVST_ADDR;

	always_comb
	begin
		chWrData = 2'b00;
		chWrSci  = 2'b00;
		chWrSmi  = 2'b00;
		chRdData = 2'b00;
		chRdSci  = 2'b00;
		chWrSt   = 2'b00;
		chWrCtl  = 2'b00;
		chWrData[ch2] = wrStb && sel == HPM_DO;
		chWrSci[ch2]  = wrStb && sel == HPM_DOC;
		chWrSmi[ch2]  = wrStb && sel == HPM_DOM;
		chWrSt[ch2]   = wrStb && sel == HPM_ST;
		chWrCtl[ch2]  = wrStb && sel == HPM_CTL;
		chRdData[ch2] = rdStb && sel == HPM_DI;
		chRdSci[ch2]  = rdStb && sel == HPM_DIC;
	end

	// both shared enables, used only by channel one since channel two stays enhanced, arrive from another block's clock
	hpm_sync u_sync_ibf
	(
		.clk  (clk),
		.srst (srst),
		.din  (sharedIbfIe),
		.dout (ibfIeSync[0])
	);
	hpm_sync u_sync_obe
	(
		.clk  (clk),
		.srst (srst),
		.din  (sharedObeIe),
		.dout (ibfIeSync[1])
	);

	hpm_channel #(.FIXED_EME(1'b0)) u_ch1
	(
		.clk          (clk),
		.srst         (srst),
		.wrData       (chWrData[0]),
		.wrSci        (chWrSci[0]),
		.wrSmi        (chWrSmi[0]),
		.rdData       (chRdData[0]),
		.rdSci        (chRdSci[0]),
		.wrSt         (chWrSt[0]),
		.wrCtl        (chWrCtl[0]),
		.wdata        (wdata),
		.hostWrPulse  (hostWr[0]),
		.hostCmd      (hostCmd[0]),
		.hostWdata    (hostWdata),
		.hostRdPulse  (hostRd[0]),
		.outLatch_r   (out1),
		.inLatch_r    (in1),
		.status_r     (st1),
		.ctl_r        (ctl1),
		.smiPending_r (smiPend[0]),
		.sciPending_r (sciPend[0]),
		.inSci_r      (inSci[0]),
		.smiPulse_r   (smiP[0]),
		.sciPulse_r   (sciP[0])
	);

	hpm_channel #(.FIXED_EME(1'b1)) u_ch2
	(
		.clk          (clk),
		.srst         (srst),
		.wrData       (chWrData[1]),
		.wrSci        (chWrSci[1]),
		.wrSmi        (chWrSmi[1]),
		.rdData       (chRdData[1]),
		.rdSci        (chRdSci[1]),
		.wrSt         (chWrSt[1]),
		.wrCtl        (chWrCtl[1]),
		.wdata        (wdata),
		.hostWrPulse  (hostWr[1]),
		.hostCmd      (hostCmd[1]),
		.hostWdata    (hostWdata),
		.hostRdPulse  (hostRd[1]),
		.outLatch_r   (out2),
		.inLatch_r    (in2),
		.status_r     (st2),
		.ctl_r        (ctl2),
		.smiPending_r (smiPend[1]),
		.sciPending_r (sciPend[1]),
		.inSci_r      (inSci[1]),
		.smiPulse_r   (smiP[1]),
		.sciPulse_r   (sciP[1])
	);

	always_ff @(posedge clk)
	begin
		if (srst)
			rdata <= 8'h00;
		else if (rdStb)
		begin
			unique case (sel)
				HPM_ST:         rdata <= ch2 ? st2 : st1;
				HPM_DI, HPM_DIC: rdata <= ch2 ? in2 : in1;
				HPM_CTL:        rdata <= ch2 ? ctl2 : ctl1;
				HPM_NONE:       rdata <= addr == `HPM_EVST_ADDR ? evStatus_r :
					addr == `HPM_EVMASK_ADDR ? evMask_r : 8'h00;
				// write-only registers read as zero
				HPM_DO, HPM_DOC, HPM_DOM: rdata <= 8'h00;
			endcase
		end
		else
			rdata <= 8'h00;
	end

	// host sees output latch; a stable copy keeps the port registered
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			hostRdata1 <= 8'h00;
			hostRdata2 <= 8'h00;
		end
		else
		begin
			hostRdata1 <= out1;
			hostRdata2 <= out2;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			hostSmi <= 2'b00;
			hostSci <= 2'b00;
		end
		else
		begin
			hostSmi <= smiP;
			hostSci <= sciP;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			evMask_r <= 8'h00;
		else if (wrStb && addr == `HPM_EVMASK_ADDR)
			evMask_r <= wdata;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			obfPrev_r <= 2'b00;
			ibfPrev_r <= 2'b00;
		end
		else
		begin
			obfPrev_r <= {st2[`HPM_ST_OBF_BIT], st1[`HPM_ST_OBF_BIT]};
			ibfPrev_r <= {st2[`HPM_ST_IBF_BIT], st1[`HPM_ST_IBF_BIT]};
		end
	end

	// core events: legacy takes shared enables, enhanced own enables
	function automatic logic [3:0] ch_events(input logic enhanced_mode_enable, input hpm_byte_t ctl,
		input logic shIbf, input logic shObe, input logic ibfRise, input logic obfFall,
		input logic smi, input logic sci);
		logic ibfEn;
		logic obeEn;
		ibfEn = enhanced_mode_enable ? ctl[`HPM_CTL_IBFIE_BIT] : shIbf;
		obeEn = enhanced_mode_enable ? ctl[`HPM_CTL_OBEIE_BIT] : shObe;
		ch_events = {sci, smi, obeEn & obfFall, ibfEn & ibfRise};
	endfunction

	logic [7:0] evSet;
	assign evSet = {
		ch_events(ctl2[`HPM_CTL_EME_BIT], ctl2, ibfIeSync[0], ibfIeSync[1],
			st2[`HPM_ST_IBF_BIT] & ~ibfPrev_r[1], ~st2[`HPM_ST_OBF_BIT] & obfPrev_r[1],
			smiP[1], sciP[1]),
		ch_events(ctl1[`HPM_CTL_EME_BIT], ctl1, ibfIeSync[0], ibfIeSync[1],
			st1[`HPM_ST_IBF_BIT] & ~ibfPrev_r[0], ~st1[`HPM_ST_OBF_BIT] & obfPrev_r[0],
			smiP[0], sciP[0])};

	// read clears, but an event in the same cycle survives
	always_ff @(posedge clk)
	begin
		if (srst)
			evStatus_r <= `HPM_EV_RST;
		else
			evStatus_r <= (evRead ? 8'h00 : evStatus_r) | evSet;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			coreIrq <= 1'b0;
		else
			coreIrq <= |(((evRead ? 8'h00 : evStatus_r) | evSet) & evMask_r);
	end

	ch1_legacy_a: assert property (@(posedge clk) $fell(srst) |-> !ctl1[`HPM_CTL_EME_BIT])
		else $error("channel one did not reset to legacy");
	sci_out_a: assert property (@(posedge clk) disable iff (srst)
		wrStb && sel == HPM_DOC && !ch2 |=> ##1 hostSci[0] == ctl1[`HPM_CTL_EME_BIT])
		else $error("host sci did not follow sci write");
	rd_zero_a: assert property (@(posedge clk) disable iff (srst)
		!$past(rdStb) |-> rdata == 8'h00)
		else $error("read data stood beyond one cycle");

	ev_irq_c: cover property (@(posedge clk) coreIrq ##1 evRead);
	ch2_smi_c: cover property (@(posedge clk) hostSmi[1]);
endmodule // hpm_top
